/* File: psm_mux_bus_ctrl.sv */
/*
  Multiplexed 16-bit memory bus controller for a pseudo-static RAM: register
  file, host access port and bus cycle sequencer.
  Assumes host and register port on core_clk and memory inputs asynchronous.
*/
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`include "psm_map.svh"
module psm_mux_bus_ctrl
  import psm_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [22:0] req_addr,
  input wire logic [1:0] req_be,
  input wire logic [15:0] req_wdata,
  input wire logic [3:0] req_beats,
  output logic rsp_done,
  output logic [15:0] rsp_rdata,
  output logic psram_chip_select_n,
  output logic address_latch_strobe,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic upper_byte_select_n,
  output logic lower_byte_select_n,
  input wire logic [15:0] ad_in,
  output logic [15:0] ad_out,
  output logic ad_oe,
  output logic [5:0] addr_high,
  output logic config_reg_select,
  input wire logic mem_wait_n,
  output logic bus_clk_en
);
  typedef struct packed {
    psm_state_e st;
    logic [31:0] bank;
    logic [31:0] rwait;
    logic [31:0] rdly;
    logic [31:0] wwait;
    logic [31:0] wdly;
    logic [31:0] idle;
    logic [31:0] brw;
    logic [31:0] port;
    logic [31:0] clkdiv;
    logic [31:0] scr0;
    logic [31:0] gptype;
    logic [31:0] p7sel;
    logic [31:0] p6sel;
    logic [31:0] p5sel;
    logic [31:0] p6dat;
    logic [31:0] bus_rdata;
    logic [15:0] wdata;
    logic [1:0] be;
    logic wr;
    logic [3:0] beats;
    psm_cnt_t dlen;
    logic ready;
    logic done;
    logic [15:0] rdata;
    logic cs_n;
    logic ale;
    logic rd_n;
    logic we_n;
    logic ub_n;
    logic lb_n;
    logic oe;
    logic [15:0] ad;
    logic [5:0] a_hi;
    logic cfg_sel;
    logic [1:0] cap;
    logic bclk;
  } psm_ctrl_s;

  psm_ctrl_s s_r;
  psm_ctrl_s s_nxt;
  psm_cnt_t ph_cnt;
  psm_cnt_t bt_cnt;
  logic [15:0] ad_sync;
  logic wait_sync;
  logic ph_ld;
  logic bt_ld;
  logic bt_run;
  psm_cnt_t ph_val;
  psm_cnt_t bt_val;

  psm_sync2 #(.W(16)) u_ad_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .din(ad_in),
    .dout(ad_sync)
  );

  psm_sync2 #(.W(1)) u_wait_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .din(mem_wait_n),
    .dout(wait_sync)
  );

  psm_down_cnt u_phase (
    .core_clk(core_clk),
    .nrst(nrst),
    .load(ph_ld),
    .run(1'b1),
    .load_val(ph_val),
    .count(ph_cnt)
  );

  psm_down_cnt u_beat (
    .core_clk(core_clk),
    .nrst(nrst),
    .load(bt_ld),
    .run(bt_run),
    .load_val(bt_val),
    .count(bt_cnt)
  );

  always_comb begin
    logic ale_on;
    logic fin;
    logic wp;
    logic burst;
    logic strobe;
    logic sync_mode;
    psm_cnt_t ws;
    psm_cnt_t dl;
    psm_cnt_t ph_after;
    psm_cnt_t elapsed;
    ale_on = 1'b0;
    fin = 1'b0;
    wp = 1'b0;
    burst = 1'b0;
    strobe = 1'b0;
    sync_mode = 1'b0;
    ws = 5'h00;
    dl = 5'h00;
    ph_after = 5'h00;
    elapsed = 5'h00;
    n_init();
    ph_ld = 1'b0;
    ph_val = 5'h00;
    bt_ld = 1'b0;
    bt_val = 5'h00;
    bt_run = 1'b0;
    // Pin data reach us two clocks late through the synchroniser, so a
    // sample taken at a strobe edge is picked up two clocks afterwards.
    s_nxt.cap = {s_r.cap[0], 1'b0};
    if (s_r.cap[1]) begin
      s_nxt.rdata = ad_sync;
      s_nxt.done = 1'b1;
    end
    // Active level of the latch strobe follows the polarity bit.
    ale_on = s_r.scr0[`PSM_SCR_ALE_POL];
    wp = s_r.bank[`PSM_BANK_WP];
    ws = s_r.wr ? s_r.wwait[4:0] : s_r.rwait[4:0];
    dl = (ws < 5'(`PSM_ACCESS_CYC)) ? 5'(`PSM_ACCESS_CYC) : ws;
    burst = s_r.wr ?
      (s_r.bank[`PSM_BANK_BWR] & s_r.bank[`PSM_BANK_SWR]) :
      (s_r.bank[`PSM_BANK_BRM] & s_r.bank[`PSM_BANK_SRD]);
    case (s_r.st)
      PSM_IDLE: begin
        if (req_valid && s_r.ready) begin
          s_nxt.st = PSM_LATCH;
          s_nxt.wr = req_write;
          s_nxt.be = req_be;
          s_nxt.wdata = req_wdata;
          s_nxt.beats = req_beats;
          s_nxt.ale = ale_on;
          s_nxt.cs_n = 1'b0;
          s_nxt.ad = req_addr[16:1];
          s_nxt.a_hi = req_addr[22:17];
          s_nxt.oe = 1'b1;
          ph_ld = 1'b1;
          ph_val = s_r.scr0[`PSM_SCR_ALE_LEN] ? 5'h01 : 5'h00;
        end
      end
      PSM_LATCH: begin
        if (ph_cnt == 5'h00) begin
          s_nxt.st = PSM_DATA;
          s_nxt.ale = ~ale_on;
          s_nxt.oe = s_r.wr & ~wp;
          s_nxt.ad = s_r.wr ? s_r.wdata : 16'h0000;
          s_nxt.dlen = dl;
          ph_ld = 1'b1;
          ph_val = dl - 5'h01;
        end
      end
      PSM_DATA: begin
        if (ph_cnt == 5'h00) begin
          if (!s_r.wr) begin
            s_nxt.cap[0] = 1'b1;
          end
          if (burst && s_r.beats > 4'h1) begin
            s_nxt.st = PSM_BEAT;
            bt_ld = 1'b1;
            bt_val = 5'(s_r.beats - 4'h2);
            if (s_r.wr) begin
              s_nxt.ad = req_wdata;
            end
          end else begin
            fin = 1'b1;
          end
        end
      end
      PSM_BEAT: begin
        bt_run = wait_sync;
        if (wait_sync) begin
          if (!s_r.wr) begin
            s_nxt.cap[0] = 1'b1;
          end else begin
            s_nxt.ad = req_wdata;
          end
          if (bt_cnt == 5'h00) begin
            fin = 1'b1;
          end
        end
      end
      PSM_GAP: begin
        if (ph_cnt == 5'h00) begin
          s_nxt.st = PSM_IDLE;
        end
      end
      default: begin
        s_nxt.st = PSM_IDLE;
      end
    endcase
    if (fin) begin
      s_nxt.cs_n = 1'b1;
      s_nxt.oe = 1'b0;
      s_nxt.done = s_nxt.done | s_r.wr;
      s_nxt.st = (s_r.idle[3:0] == 4'h0) ? PSM_IDLE : PSM_GAP;
      ph_ld = 1'b1;
      ph_val = 5'(s_r.idle[3:0] - 4'h1);
    end
    ph_after = ph_ld ? ph_val :
      ((ph_cnt == 5'h00) ? 5'h00 : ph_cnt - 5'h01);
    elapsed = s_nxt.dlen - 5'h01 - ph_after;
    strobe = (s_nxt.st == PSM_DATA &&
      elapsed >= (s_nxt.wr ? {1'b0, s_r.wdly[3:0]} :
      {1'b0, s_r.rdly[3:0]})) || s_nxt.st == PSM_BEAT;
    s_nxt.rd_n = ~(strobe & ~s_nxt.wr);
    s_nxt.we_n = ~(strobe & s_nxt.wr & ~wp);
    if (!s_nxt.cs_n && s_r.port[`PSM_PORT_BYTE] &&
        s_r.bank[`PSM_BANK_LANE] &&
        s_r.bank[`PSM_BANK_WIDTH_HI:`PSM_BANK_WIDTH_LO] == `PSM_WIDTH_16)
        begin
      s_nxt.ub_n = ~s_nxt.be[1];
      s_nxt.lb_n = ~s_nxt.be[0];
    end else begin
      s_nxt.ub_n = 1'b1;
      s_nxt.lb_n = 1'b1;
    end
    if (s_r.st == PSM_IDLE && s_nxt.st == PSM_IDLE) begin
      s_nxt.cfg_sel = s_r.p6dat[0];
    end
    sync_mode = s_r.bank[`PSM_BANK_SRD] | s_r.bank[`PSM_BANK_SWR];
    s_nxt.bclk = sync_mode & s_r.port[`PSM_PORT_BCLK] & ~s_nxt.cs_n &
      (s_r.clkdiv[`PSM_CLK_RATIO_HI:`PSM_CLK_RATIO_LO] == 2'h0);
    s_nxt.ready = (s_nxt.st == PSM_IDLE);
  end

  // Register port: one-cycle writes, reads answered in the next cycle.
  function automatic void n_init();
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.bus_rdata = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        `PSM_OFS_BANK: s_nxt.bank = reg_wdata;
        `PSM_OFS_RWAIT: s_nxt.rwait = reg_wdata;
        `PSM_OFS_RDLY: s_nxt.rdly = reg_wdata;
        `PSM_OFS_WWAIT: s_nxt.wwait = reg_wdata;
        `PSM_OFS_WDLY: s_nxt.wdly = reg_wdata;
        `PSM_OFS_IDLE: s_nxt.idle = reg_wdata;
        `PSM_OFS_BRW: s_nxt.brw = reg_wdata;
        `PSM_OFS_PORT: s_nxt.port = reg_wdata;
        `PSM_OFS_CLKDIV: s_nxt.clkdiv = reg_wdata;
        `PSM_OFS_SCR0: s_nxt.scr0 = reg_wdata;
        `PSM_OFS_GPTYPE: s_nxt.gptype = reg_wdata;
        `PSM_OFS_P7SEL: s_nxt.p7sel = reg_wdata;
        `PSM_OFS_P6SEL: s_nxt.p6sel = reg_wdata;
        `PSM_OFS_P5SEL: s_nxt.p5sel = reg_wdata;
        `PSM_OFS_P6DAT: s_nxt.p6dat = reg_wdata;
        default: s_nxt.bus_rdata = 32'h0000_0000;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `PSM_OFS_BANK: s_nxt.bus_rdata = s_r.bank;
        `PSM_OFS_RWAIT: s_nxt.bus_rdata = s_r.rwait;
        `PSM_OFS_RDLY: s_nxt.bus_rdata = s_r.rdly;
        `PSM_OFS_WWAIT: s_nxt.bus_rdata = s_r.wwait;
        `PSM_OFS_WDLY: s_nxt.bus_rdata = s_r.wdly;
        `PSM_OFS_IDLE: s_nxt.bus_rdata = s_r.idle;
        `PSM_OFS_BRW: s_nxt.bus_rdata = s_r.brw;
        `PSM_OFS_PORT: s_nxt.bus_rdata = s_r.port;
        `PSM_OFS_CLKDIV: s_nxt.bus_rdata = s_r.clkdiv;
        `PSM_OFS_SCR0: s_nxt.bus_rdata = s_r.scr0;
        `PSM_OFS_GPTYPE: s_nxt.bus_rdata = s_r.gptype;
        `PSM_OFS_P7SEL: s_nxt.bus_rdata = s_r.p7sel;
        `PSM_OFS_P6SEL: s_nxt.bus_rdata = s_r.p6sel;
        `PSM_OFS_P5SEL: s_nxt.bus_rdata = s_r.p5sel;
        // Reading back the pin shows which space the memory answers from.
        `PSM_OFS_P6DAT: s_nxt.bus_rdata = {s_r.p6dat[31:1], s_r.cfg_sel};
        default: s_nxt.bus_rdata = 32'h0000_0000;
      endcase
    end
  endfunction

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.bank <= `PSM_RST_BANK;
      s_r.rwait <= `PSM_RST_RWAIT;
      s_r.rdly <= `PSM_RST_RDLY;
      s_r.wwait <= `PSM_RST_WWAIT;
      s_r.wdly <= `PSM_RST_WDLY;
      s_r.idle <= `PSM_RST_IDLE;
      s_r.brw <= `PSM_RST_BRW;
      s_r.port <= `PSM_RST_PORT;
      s_r.clkdiv <= `PSM_RST_CLKDIV;
      s_r.scr0 <= `PSM_RST_SCR0;
      s_r.gptype <= `PSM_RST_GPTYPE;
      s_r.p7sel <= `PSM_RST_P7SEL;
      s_r.p6sel <= `PSM_RST_P6SEL;
      s_r.p5sel <= `PSM_RST_P5SEL;
      s_r.p6dat <= `PSM_RST_P6DAT;
      s_r.ready <= 1'b1;
      s_r.cs_n <= 1'b1;
      s_r.ale <= 1'b1;
      s_r.rd_n <= 1'b1;
      s_r.we_n <= 1'b1;
      s_r.ub_n <= 1'b1;
      s_r.lb_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.bus_rdata;
  assign req_ready = s_r.ready;
  assign rsp_done = s_r.done;
  assign rsp_rdata = s_r.rdata;
  assign psram_chip_select_n = s_r.cs_n;
  assign address_latch_strobe = s_r.ale;
  assign read_strobe_n = s_r.rd_n;
  assign write_strobe_n = s_r.we_n;
  assign upper_byte_select_n = s_r.ub_n;
  assign lower_byte_select_n = s_r.lb_n;
  assign ad_out = s_r.ad;
  assign ad_oe = s_r.oe;
  assign addr_high = s_r.a_hi;
  assign config_reg_select = s_r.cfg_sel;
  assign bus_clk_en = s_r.bclk;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_latch_start: assert property ($fell(s_r.cs_n) |->
    s_r.ale == s_r.scr0[`PSM_SCR_ALE_POL]) else $error("latch idle");
  a_latch_width: assert property (($fell(s_r.ale) &&
    s_r.scr0[`PSM_SCR_ALE_LEN]) |-> ##1 !s_r.ale ##1 s_r.ale)
    else $error("latch width wrong");
  a_read_delay: assert property ((s_r.st == PSM_LATCH &&
    ph_cnt == 5'h00 && !s_r.wr && s_r.rdly[3:0] == 4'h4 &&
    s_r.rwait[4:0] == 5'h05 && !reg_wr) |->
    ##1 s_r.rd_n [*4] ##1 !s_r.rd_n) else $error("read delay wrong");
  a_write_nodelay: assert property ((s_r.st == PSM_LATCH &&
    ph_cnt == 5'h00 && s_r.wr && s_r.wdly[3:0] == 4'h0 && !reg_wr &&
    !s_r.bank[`PSM_BANK_WP]) |-> ##1 !s_r.we_n)
    else $error("write strobe late");
  a_write_prot: assert property ((s_r.bank[`PSM_BANK_WP] &&
    $stable(s_r.bank)) |-> s_r.we_n) else $error("protected write");
  a_cs_span: assert property ((s_r.st == PSM_LATCH ||
    s_r.st == PSM_DATA || s_r.st == PSM_BEAT) |-> !s_r.cs_n &&
    !s_r.ready) else $error("chip select dropped");
  a_addr_shift: assert property ($past(req_valid && s_r.ready)
    |-> s_r.ad == $past(req_addr[16:1]) &&
    s_r.a_hi == $past(req_addr[22:17])) else $error("address shift");
  a_bclk_async: assert property (!$past(s_r.bank[`PSM_BANK_SRD] |
    s_r.bank[`PSM_BANK_SWR]) |-> !s_r.bclk) else $error("bus clock on");
  a_cfgsel_hold: assert property ((s_r.st != PSM_IDLE) |=>
    $stable(s_r.cfg_sel)) else $error("config select moved mid-cycle");
  a_lane_off: assert property (!$past(s_r.port[`PSM_PORT_BYTE] &
    s_r.bank[`PSM_BANK_LANE]) |-> s_r.ub_n && s_r.lb_n)
    else $error("byte select driven");
endmodule

/* File: psm_map.svh */
/*
  Register offsets, field positions, reset values and timing counts of the
  multiplexed memory bus controller.
  Assumes it is included by its bare name wherever one of them is needed.
*/
`ifndef PSM_MAP_SVH
`define PSM_MAP_SVH

`define PSM_OFS_BANK 6'h00
`define PSM_OFS_RWAIT 6'h04
`define PSM_OFS_RDLY 6'h08
`define PSM_OFS_WWAIT 6'h0C
`define PSM_OFS_WDLY 6'h10
`define PSM_OFS_IDLE 6'h14
`define PSM_OFS_BRW 6'h18
`define PSM_OFS_PORT 6'h1C
`define PSM_OFS_CLKDIV 6'h20
`define PSM_OFS_SCR0 6'h24
`define PSM_OFS_GPTYPE 6'h28
`define PSM_OFS_P7SEL 6'h2C
`define PSM_OFS_P6SEL 6'h30
`define PSM_OFS_P5SEL 6'h34
`define PSM_OFS_P6DAT 6'h38

`define PSM_RST_BANK 32'h0000_0011
`define PSM_RST_RWAIT 32'h0000_0005
`define PSM_RST_RDLY 32'h0000_0004
`define PSM_RST_WWAIT 32'h0000_0005
`define PSM_RST_WDLY 32'h0000_0000
`define PSM_RST_IDLE 32'h0000_0003
`define PSM_RST_BRW 32'h0000_0000
`define PSM_RST_PORT 32'h0000_0005
`define PSM_RST_CLKDIV 32'h0000_0000
`define PSM_RST_SCR0 32'h0000_0100
`define PSM_RST_GPTYPE 32'h0000_0000
`define PSM_RST_P7SEL 32'h0000_0AAA
`define PSM_RST_P6SEL 32'h0000_0001
`define PSM_RST_P5SEL 32'h0000_0C00
`define PSM_RST_P6DAT 32'h0000_0000

`define PSM_BANK_LANE 0
`define PSM_BANK_WP 3
`define PSM_BANK_WIDTH_HI 5
`define PSM_BANK_WIDTH_LO 4
`define PSM_BANK_BRM 8
`define PSM_BANK_SRD 9
`define PSM_BANK_BWR 16
`define PSM_BANK_SWR 17
`define PSM_WIDTH_16 2'h1
`define PSM_PORT_BCLK 1
`define PSM_PORT_BYTE 2
`define PSM_CLK_RATIO_HI 18
`define PSM_CLK_RATIO_LO 17
`define PSM_SCR_ALE_LEN 8
`define PSM_SCR_ALE_POL 7

`define PSM_CLK_NS 50
`define PSM_ACCESS_NS 70
`define PSM_ACCESS_CYC ((`PSM_ACCESS_NS + `PSM_CLK_NS - 1) / `PSM_CLK_NS)

`endif

/* File: psm_pkg.sv */
/*
  Types shared by the multiplexed memory bus controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package psm_pkg;

  typedef enum logic [2:0] {
    PSM_IDLE = 3'h0,
    PSM_LATCH = 3'h1,
    PSM_DATA = 3'h2,
    PSM_BEAT = 3'h3,
    PSM_GAP = 3'h4
  } psm_state_e;

  typedef logic [4:0] psm_cnt_t;

endpackage

/* File: psm_sync2.sv */
/*
  Two-stage synchroniser for inputs arriving from the memory pins.
  Assumes the input has no timing relation to core_clk.
*/
`timescale 1ns/1ps
module psm_sync2 #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] q1;
    logic [W-1:0] q2;
  } psm_sync_s;

  psm_sync_s s_r;
  psm_sync_s s_nxt;

  // The first stage feeds only the second one.
  always_comb begin
    s_nxt.q1 = din;
    s_nxt.q2 = s_r.q1;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.q2;
endmodule

/* File: psm_down_cnt.sv */
/*
  Loadable down counter that stops at zero, used for bus phase timing.
  Assumes load and run come from logic on core_clk.
*/
`timescale 1ns/1ps
module psm_down_cnt
  import psm_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic run,
  input wire psm_cnt_t load_val,
  output psm_cnt_t count
);
  typedef struct packed {
    psm_cnt_t cnt;
  } psm_cnt_s;

  psm_cnt_s s_r;
  psm_cnt_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (load) begin
      s_nxt.cnt = load_val;
    end else if (run && s_r.cnt != 5'h00) begin
      s_nxt.cnt = s_r.cnt - 5'h01;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count = s_r.cnt;
endmodule

/* File: psm_psram_model.sv */
/*
  Pin-level model of the pseudo-static RAM on the multiplexed bus.
  Assumes core_clk only as a mid-cycle point to sample settled pin levels.
*/
`timescale 1ns/1ps
module psm_psram_model (
  input wire logic core_clk,
  input wire logic cs_n,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic we_n,
  input wire logic ub_n,
  input wire logic lb_n,
  input wire logic cfg_sel,
  input wire logic [15:0] ad_out,
  input wire logic [5:0] addr_high,
  output logic [15:0] ad_in,
  output logic wait_n,
  output logic [21:0] lat,
  output logic [21:0] cfg
);
  logic [15:0] mem [0:255];
  logic [15:0] last;
  logic [15:0] cur;
  logic [21:0] p_a;
  logic [15:0] p_d;
  logic p_ale, p_we, p_ub, p_lb, p_sel;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h0000;
    end
    cfg = 22'h008000;
    lat = 22'h000000;
    last = 16'h0000;
    p_ale = 1'b1;
    p_we = 1'b1;
  end
  assign cur = cfg_sel ? cfg[15:0] : mem[lat[7:0]];
  // wait stays asserted in async mode; the controller must ignore it.
  assign wait_n = ~cfg[15];
  // lines show the inverse of the last read value when not reading, so stale data never looks valid.
  assign ad_in = (!cs_n && !rd_n) ? cur : ~last;
  // capture on strobe rise, value from address lines.
  always @(negedge core_clk) begin
    if (!p_ale && ale) begin
      lat <= p_a;
    end
    if (!p_we && we_n) begin
      if (p_sel) begin
        cfg <= lat;
      end else begin
        if (!p_ub) begin
          mem[lat[7:0]][15:8] <= p_d[15:8];
        end
        if (!p_lb) begin
          mem[lat[7:0]][7:0] <= p_d[7:0];
        end
      end
    end
    if (!cs_n && !rd_n) begin
      last <= cur;
    end
    p_ale <= ale;
    p_we <= we_n;
    p_ub <= ub_n;
    p_lb <= lb_n;
    p_sel <= cfg_sel;
    p_a <= {addr_high, ad_out};
    p_d <= ad_out;
  end
endmodule

/* File: psm_mux_bus_ctrl_tb_top.sv */
/*
  Self-checking bench for the multiplexed memory bus controller.
  Assumes the register map header and the pin model of the memory.
*/
`timescale 1ns/1ps
`include "psm_map.svh"
module psm_mux_bus_ctrl_tb_top;
  logic core_clk, nrst, reg_wr, reg_rd, req_valid, req_ready, req_write;
  logic rsp_done, cs_n, ale, rd_n, we_n, ub_n, lb_n, ad_oe, cfg_sel, wait_n;
  logic bclk_en;
  logic [5:0] reg_addr, addr_high;
  logic [31:0] reg_wdata, reg_rdata;
  logic [22:0] req_addr;
  logic [1:0] req_be;
  logic [15:0] req_wdata, rsp_rdata, ad_in, ad_out;
  logic [3:0] req_beats;
  logic [21:0] lat, cfg;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int cs_c, ale_c, rd_c, we_c, ub_c, lb_c, bk_c, dn_c, oe_c;

  psm_mux_bus_ctrl DUT (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_be(req_be),
    .req_wdata(req_wdata), .req_beats(req_beats), .rsp_done(rsp_done),
    .rsp_rdata(rsp_rdata), .psram_chip_select_n(cs_n),
    .address_latch_strobe(ale), .read_strobe_n(rd_n),
    .write_strobe_n(we_n), .upper_byte_select_n(ub_n),
    .lower_byte_select_n(lb_n), .ad_in(ad_in), .ad_out(ad_out),
    .ad_oe(ad_oe), .addr_high(addr_high), .config_reg_select(cfg_sel),
    .mem_wait_n(wait_n), .bus_clk_en(bclk_en)
  );

  psm_psram_model MEM (
    .core_clk(core_clk), .cs_n(cs_n), .ale(ale), .rd_n(rd_n),
    .we_n(we_n), .ub_n(ub_n), .lb_n(lb_n), .cfg_sel(cfg_sel),
    .ad_out(ad_out),
    .addr_high(addr_high), .ad_in(ad_in), .wait_n(wait_n), .lat(lat),
    .cfg(cfg)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Pin activity is counted per cycle so phase widths can be judged.
  always @(posedge core_clk) begin
    cs_c += int'(cs_n === 1'b0);
    ale_c += int'(ale === 1'b0);
    rd_c += int'(rd_n === 1'b0);
    we_c += int'(we_n === 1'b0);
    ub_c += int'(ub_n === 1'b0);
    lb_c += int'(lb_n === 1'b0);
    bk_c += int'(bclk_en === 1'b1);
    dn_c += int'(rsp_done === 1'b1);
    oe_c += int'(ad_oe === 1'b1);
  end

  // The whole run needs well under two thousand cycles.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Returns cycles from accept to first done, and from done to ready.
  task automatic acc(input logic w, input logic [22:0] a,
      input logic [1:0] be, input logic [15:0] d, input logic [3:0] nb,
      output int n, output int m);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_be <= be;
    req_wdata <= d;
    req_beats <= nb;
    {cs_c, ale_c, rd_c, we_c, ub_c, lb_c, bk_c, dn_c, oe_c} = '0;
    @(posedge core_clk);
    req_valid <= 1'b0;
    n = 0;
    m = 0;
    while (rsp_done !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    while (req_ready !== 1'b1 && m < 100) begin
      @(posedge core_clk);
      m++;
    end
  endtask

  task automatic t_regs;
    logic [31:0] v;
    rd(`PSM_OFS_BANK, v);
    chk(v[5:4], 2'h1);
    chk({v[17:16], v[9:8], v[3], v[0]}, 6'h01);
    rd(`PSM_OFS_RWAIT, v);
    chk(v[4:0], 5'h05);
    rd(`PSM_OFS_RDLY, v);
    chk(v[3:0], 4'h4);
    rd(`PSM_OFS_WWAIT, v);
    chk(v[4:0], 5'h05);
    rd(`PSM_OFS_WDLY, v);
    chk(v[3:0], 4'h0);
    rd(`PSM_OFS_BRW, v);
    chk(v[4:0], 5'h00);
    rd(`PSM_OFS_PORT, v);
    chk(v[2], 1'b1);
    rd(`PSM_OFS_CLKDIV, v);
    chk(v[18:17], 2'h0);
    rd(`PSM_OFS_SCR0, v);
    chk(v[8:7], 2'h2);
    wr(`PSM_OFS_GPTYPE, 32'h0000_00A5);
    rd(`PSM_OFS_GPTYPE, v);
    chk(v, 32'h0000_00A5);
    wr(6'h3C, 32'hFFFF_FFFF);
    rd(6'h3C, v);
    chk(v, 32'h0000_0000);
  endtask

  task automatic t_async;
    int n, m;
    acc(1'b1, 23'h000066, 2'h3, 16'h3CD5, 4'h0, n, m);
    chk(n, 8);
    chk(ale_c, 2);
    chk(we_c, 5);
    chk(we_c * `PSM_CLK_NS >= `PSM_ACCESS_NS, 1);
    chk(cs_c, 7);
    chk(oe_c, 7);
    chk(m, 3);
    chk(ub_c + lb_c, 14);
    chk(lat, 22'h000033);
    chk(bk_c, 0);
    acc(1'b0, 23'h000066, 2'h3, 16'h0000, 4'h0, n, m);
    chk(n, 10);
    chk(rd_c, 1);
    chk(oe_c, 2);
    chk(rsp_rdata, 16'h3CD5);
  endtask

  task automatic t_lanes;
    int n, m;
    acc(1'b1, 23'h000066, 2'h1, 16'hAA11, 4'h0, n, m);
    chk(ub_c, 0);
    chk(lb_c, 7);
    wr(`PSM_OFS_PORT, 32'h0000_0001);
    acc(1'b0, 23'h000066, 2'h3, 16'h0000, 4'h0, n, m);
    chk(ub_c + lb_c, 0);
    wr(`PSM_OFS_PORT, 32'h0000_0005);
    wr(`PSM_OFS_BANK, 32'h0000_0019);
    acc(1'b1, 23'h000066, 2'h3, 16'h0000, 4'h0, n, m);
    chk(we_c, 0);
    chk(oe_c, 2);
    chk(n, 8);
    wr(`PSM_OFS_BANK, 32'h0000_0011);
    acc(1'b0, 23'h000066, 2'h3, 16'h0000, 4'h0, n, m);
    chk(rsp_rdata, 16'h3C11);
  endtask

  task automatic t_cfg;
    int n, m;
    logic [21:0] c;
    c = {4'h2, 2'h0, 1'b0, 1'b1, 3'h4, 3'h1, 2'h0, 2'h1, 1'b1, 3'h7};
    wr(`PSM_OFS_P6DAT, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    #1 chk(cfg_sel, 1'b1);
    acc(1'b1, {c, 1'b0}, 2'h3, 16'hFFFF, 4'h0, n, m);
    chk(n, 8);
    chk(cfg, c);
    acc(1'b0, {c, 1'b0}, 2'h3, 16'h0000, 4'h0, n, m);
    chk(rsp_rdata, c[15:0]);
    wr(`PSM_OFS_P6DAT, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    #1 chk(cfg_sel, 1'b0);
  endtask

  task automatic t_burst;
    int n, m;
    wr(`PSM_OFS_BANK, 32'h0000_0311);
    wr(`PSM_OFS_PORT, 32'h0000_0007);
    acc(1'b0, 23'h000066, 2'h3, 16'h0000, 4'h4, n, m);
    chk(dn_c, 4);
    chk(n, 10);
    chk(ale_c, 2);
    chk(bk_c > 0, 1);
    wr(`PSM_OFS_BANK, 32'h0000_0011);
    wr(`PSM_OFS_PORT, 32'h0000_0005);
  endtask

  task automatic end_sim;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 23'h000000;
    req_be = 2'h0;
    req_wdata = 16'h0000;
    req_beats = 4'h0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs();
    t_async();
    t_lanes();
    t_cfg();
    t_burst();
    end_sim();
  end
endmodule
